/* File: design/boot_checker.sv */
// Boot selection: branch test and word checksums over the flash blocks.
// Assumes the flash read port answers each read pulse with a valid pulse.
`timescale 1ns/1ps
`default_nettype none
module boot_checker (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        start,
   input  wire logic [31:0] rd_data,
   input  wire logic        rd_valid,
   output logic [31:0]      rd_addr,
   output logic             rd_req,
   output logic             done,
   output logic             found,
   output logic             blk2
);
   import remap_pkg::*;

   typedef enum {C_IDLE, C_BR_REQ, C_BR_WAIT, C_SUM_REQ, C_SUM_WAIT}
      chk_e;

   chk_e        st_r;
   logic [1:0]  idx_r;
   logic [31:0] addr_r;
   logic [31:0] sum_r;
   logic        req_r;
   logic        done_r;
   logic        found_r;
   logic        blk2_r;
   logic [31:0] cur_base;
   logic [31:0] cur_ref;
   logic        is_branch;
   logic        at_ref;
   logic        last_chk;

   // Region start for each check in order: block 1, block 2, overall
   function automatic logic [31:0] base_of(input logic [1:0] k);
      base_of = (k == 2'd1) ? BLK2_BASE : BLK1_BASE;
   endfunction

   // Location of the stored checksum for each check
   function automatic logic [31:0] ref_of(input logic [1:0] k);
      unique case (k)
         2'd0:    ref_of = CK_BLK1_BOOT;
         2'd1:    ref_of = CK_BLK2_BOOT;
         default: ref_of = CK_OVERALL;
      endcase
   endfunction

   assign cur_base  = base_of(idx_r);
   assign cur_ref   = ref_of(idx_r);
   assign is_branch = (rd_data & BRANCH_MASK) == BRANCH_VAL;
   assign at_ref    = addr_r == cur_ref;
   assign last_chk  = idx_r == 2'd2;

   // Walk the checks; an empty block is skipped without summing
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r    <= C_IDLE;
         idx_r   <= 2'd0;
         addr_r  <= 32'h0000_0000;
         sum_r   <= 32'h0000_0000;
         req_r   <= 1'b0;
         done_r  <= 1'b0;
         found_r <= 1'b0;
         blk2_r  <= 1'b0;
      end else begin
         req_r  <= 1'b0;
         done_r <= 1'b0;
         unique case (st_r)
            C_IDLE: if (start) begin
               idx_r   <= 2'd0;
               found_r <= 1'b0;
               st_r    <= C_BR_REQ;
            end
            C_BR_REQ: begin
               addr_r <= cur_base;
               req_r  <= 1'b1;
               st_r   <= C_BR_WAIT;
            end
            C_BR_WAIT: if (rd_valid) begin
               if (is_branch) begin
                  sum_r <= 32'h0000_0000;
                  st_r  <= C_SUM_REQ;
               end else if (last_chk) begin
                  done_r <= 1'b1;
                  st_r   <= C_IDLE;
               end else begin
                  idx_r <= idx_r + 2'd1;
                  st_r  <= C_BR_REQ;
               end
            end
            C_SUM_REQ: begin
               req_r <= 1'b1;
               st_r  <= C_SUM_WAIT;
            end
            C_SUM_WAIT: if (rd_valid) begin
               if (!at_ref) begin
                  sum_r  <= sum_r + rd_data;
                  addr_r <= addr_r + WORD_STEP;
                  st_r   <= C_SUM_REQ;
               end else if (sum_r == rd_data) begin
                  found_r <= 1'b1;
                  blk2_r  <= idx_r == 2'd1;
                  done_r  <= 1'b1;
                  st_r    <= C_IDLE;
               end else if (last_chk) begin
                  done_r <= 1'b1;
                  st_r   <= C_IDLE;
               end else begin
                  idx_r <= idx_r + 2'd1;
                  st_r  <= C_BR_REQ;
               end
            end
         endcase
      end
   end

   assign rd_addr = addr_r;
   assign rd_req  = req_r;
   assign done    = done_r;
   assign found   = found_r;
   assign blk2    = blk2_r;
endmodule
`default_nettype wire

/* File: design/memory_remap.sv */
// Address decode and remap between ROM mode and flash mode, with boot
// selection and the half-rate slow bus. Assumes the core holds CPU_REQ
// low between accesses at least one cycle when a remap is pending.
`timescale 1ns/1ps
`default_nettype none
module memory_remap (
   input  wire logic                             SYS_CLK,
   input  wire logic                             RST,
   input  wire logic                             CPU_REQ,
   input  wire logic                             CPU_WE,
   input  wire logic [31:0]                      CPU_ADDR,
   input  wire logic                             FLASH1_BUSY,
   input  wire logic                             FLASH2_BUSY,
   input  wire logic                             F2_WR_EN,
   input  wire logic                             F2_ERASE_REQ,
   input  wire logic                             F2_LOCK,
   input  wire logic                             BOOT_SPLIT,
   input  wire logic                             BOOT_START,
   input  wire logic [31:0]                      BOOT_DATA,
   input  wire logic                             BOOT_DVALID,
   input  wire logic                             MGMT_CMD_VALID,
   input  wire logic [7:0]                       MGMT_CMD,
   output logic                                  ROM_CS,
   output logic                                  FLASH1_CS,
   output logic                                  FLASH2_CS,
   output logic                                  FLASH2_WE,
   output logic                                  FLASH2_ERASE,
   output logic                                  FAST_CS,
   output logic [remap_pkg::ROM_OFS_W-1:0]       ROM_OFS,
   output logic [remap_pkg::FLASH_OFS_W-1:0]     FLASH_OFS,
   output logic [31:0]                           FAST_ADDR,
   output logic                                  MEM_WE,
   output logic                                  ACC_DONE,
   output logic                                  CPU_WAIT,
   output logic                                  BOOT_REGION,
   output logic                                  IO_CLK,
   output logic                                  IO_STB,
   output logic                                  IO_WE,
   output logic [31:0]                           IO_ADDR,
   output logic [31:0]                           BOOT_RD_ADDR,
   output logic                                  BOOT_RD_REQ,
   output logic                                  BOOT_DONE,
   output logic                                  ROM_MODE,
   output logic                                  BLK2_AT_ZERO,
   output logic                                  JUMP_REQ,
   output logic [31:0]                           JUMP_ADDR
);
   import remap_pkg::*;

   typedef enum {M_ROM, M_ROM_HIGH, M_FLASH} mode_e;

   mode_e       mode_r;
   mode_e       mode_nxt;
   logic        blk2_r;
   logic        blk2_nxt;
   logic        pend_r;
   logic        pend_blk2_r;
   logic        rom_cs_r;
   logic        f1_cs_r;
   logic        f2_cs_r;
   logic        f2_we_r;
   logic        f2_erase_r;
   logic        fast_cs_r;
   logic [ROM_OFS_W-1:0]   rom_ofs_r;
   logic [FLASH_OFS_W-1:0] flash_ofs_r;
   logic [31:0] fast_addr_r;
   logic        we_r;
   logic        done_r;
   logic        wait_r;
   logic        boot_rgn_r;
   logic        jump_r;
   logic        rom_mode_r;

   logic        boot_done;
   logic        boot_found;
   logic        boot_blk2;
   logic        io_busy;

   // Returns true when a lies in [base, base + size)
   function automatic logic in_win(input logic [31:0] a,
                                   input logic [31:0] base,
                                   input logic [31:0] size);
      in_win = (a >= base) && ((a - base) < size);
   endfunction

   // Address decode, all as named wires
   logic        is_slow;
   logic        rom_alias_hit;
   logic        rom_high_hit;
   logic        rom_hit;
   logic        flash_lo_hit;
   logic        flash_hi_hit;
   logic        f1_hit;
   logic        f2_hit;
   logic        fast_hit;
   logic        f1_stall;
   logic        f2_stall;
   logic        stall;
   logic        take;
   logic        quiet;
   logic        cmd_blk1;
   logic        cmd_blk2;
   logic        boot_go;
   logic        enter_req;
   logic        enter_blk2;
   logic        f2_write_ok;

   assign is_slow       = CPU_ADDR >= SLOW_BASE;
   assign rom_alias_hit = (mode_r == M_ROM) &&
                          (CPU_ADDR <= ROM_ALIAS_TOP);
   assign rom_high_hit  = in_win(CPU_ADDR, ROM_HI_BASE, ROM_SIZE);
   assign rom_hit       = rom_alias_hit || (rom_high_hit && !is_slow);
   assign flash_lo_hit  = (mode_r == M_FLASH) &&
                          in_win(CPU_ADDR, 32'h0000_0000, FLASH_BLK_SIZE);
   assign flash_hi_hit  = (mode_r == M_FLASH) &&
                          in_win(CPU_ADDR, FLASH_ALT_BASE, FLASH_BLK_SIZE);
   // Block at zero is the selected one; the other always at 0x8000
   assign f1_hit        = blk2_r ? flash_hi_hit : flash_lo_hit;
   assign f2_hit        = blk2_r ? flash_lo_hit : flash_hi_hit;
   // Fast window decoded by the same range scheme as the memories
   assign fast_hit      = in_win(CPU_ADDR, FAST_OLD_BASE + FAST_RELOC,
                                 FAST_SIZE);
   // A busy block stalls only accesses aimed at that block
   assign f1_stall      = f1_hit && FLASH1_BUSY;
   assign f2_stall      = f2_hit && FLASH2_BUSY;
   assign stall         = f1_stall || f2_stall || (is_slow && io_busy);
   assign take          = CPU_REQ && !stall;
   assign quiet         = !CPU_REQ;

   // Execute codes and the boot result both request flash mode
   assign cmd_blk1      = MGMT_CMD_VALID && (MGMT_CMD == CMD_EXEC_BLK1);
   assign cmd_blk2      = MGMT_CMD_VALID && (MGMT_CMD == CMD_EXEC_BLK2);
   assign boot_go       = boot_done && boot_found;
   assign enter_req     = cmd_blk1 || cmd_blk2 || boot_go;
   assign enter_blk2    = cmd_blk2 || (!cmd_blk1 && boot_go && boot_blk2);

   // Writes into block two need its enable and no interlock
   assign f2_write_ok   = F2_WR_EN && !F2_LOCK;

   // Remap sequence; every step waits for a gap between accesses
   always_comb begin
      mode_nxt = mode_r;
      blk2_nxt = blk2_r;
      unique case (mode_r)
         M_ROM: if (pend_r && quiet) begin
            mode_nxt = M_ROM_HIGH;
         end
         M_ROM_HIGH: if (quiet) begin
            mode_nxt = M_FLASH;
            blk2_nxt = pend_blk2_r;
         end
         M_FLASH: if (pend_r && quiet) begin
            blk2_nxt = pend_blk2_r;
         end
      endcase
   end

   // Mode and block selection commit atomically at a quiet edge
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         mode_r <= M_ROM;
         blk2_r <= 1'b0;
         rom_mode_r <= 1'b1;
      end else begin
         mode_r <= mode_nxt;
         blk2_r <= blk2_nxt;
         // Registered copy so the mode pin never carries decode glitches
         rom_mode_r <= mode_nxt == M_ROM;
      end
   end

   // Pending hand-over; a new request wins over the clearing step
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         pend_r      <= 1'b0;
         pend_blk2_r <= 1'b0;
      end else if (enter_req) begin
         pend_r      <= 1'b1;
         pend_blk2_r <= enter_blk2;
      end else if (quiet && mode_r != M_ROM) begin
         pend_r      <= 1'b0;
      end
   end

   // Jump through the vector once the chosen block lands at zero
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         jump_r <= 1'b0;
      end else begin
         jump_r <= (mode_r != M_FLASH && mode_nxt == M_FLASH) ||
                   (mode_r == M_FLASH && pend_r && quiet);
      end
   end

   // Chip selects; unmapped addresses raise none of them
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         rom_cs_r  <= 1'b0;
         f1_cs_r   <= 1'b0;
         f2_cs_r   <= 1'b0;
         fast_cs_r <= 1'b0;
         f2_we_r   <= 1'b0;
      end else begin
         rom_cs_r  <= take && rom_hit && !CPU_WE;
         f1_cs_r   <= take && f1_hit;
         f2_cs_r   <= take && f2_hit;
         fast_cs_r <= take && fast_hit && !is_slow;
         f2_we_r   <= take && f2_hit && CPU_WE && f2_write_ok;
      end
   end

   // Offsets into each target and completion of every taken access
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         rom_ofs_r   <= '0;
         flash_ofs_r <= '0;
         fast_addr_r <= 32'h0000_0000;
         we_r        <= 1'b0;
         done_r      <= 1'b0;
         wait_r      <= 1'b0;
         boot_rgn_r  <= 1'b0;
      end else begin
         rom_ofs_r   <= CPU_ADDR[ROM_OFS_W-1:0];
         flash_ofs_r <= CPU_ADDR[FLASH_OFS_W-1:0];
         fast_addr_r <= CPU_ADDR - (FAST_OLD_BASE + FAST_RELOC);
         we_r        <= take && CPU_WE;
         done_r      <= take;
         wait_r      <= CPU_REQ && stall;
         // Small boot area at the bottom of the combined space
         boot_rgn_r  <= take && BOOT_SPLIT && flash_lo_hit &&
                        (CPU_ADDR < BOOT_RGN_SIZE);
      end
   end

   // Erase of block two is refused while the interlock is set
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         f2_erase_r <= 1'b0;
      end else begin
         f2_erase_r <= F2_ERASE_REQ && !F2_LOCK && !FLASH2_BUSY;
      end
   end

   // Slow peripherals leave through the half-rate bus unchanged
   slow_io_bus u_io (
      .clk     (SYS_CLK),
      .rst     (RST),
      .req     (take && is_slow),
      .we      (CPU_WE),
      .addr    (CPU_ADDR),
      .io_clk  (IO_CLK),
      .io_stb  (IO_STB),
      .io_we   (IO_WE),
      .io_addr (IO_ADDR),
      .busy    (io_busy)
   );

   // Boot checker reads flash words through its own port
   boot_checker u_boot (
      .clk      (SYS_CLK),
      .rst      (RST),
      .start    (BOOT_START && mode_r == M_ROM),
      .rd_data  (BOOT_DATA),
      .rd_valid (BOOT_DVALID),
      .rd_addr  (BOOT_RD_ADDR),
      .rd_req   (BOOT_RD_REQ),
      .done     (BOOT_DONE),
      .found    (boot_found),
      .blk2     (boot_blk2)
   );
   assign boot_done = BOOT_DONE;

   assign ROM_CS       = rom_cs_r;
   assign FLASH1_CS    = f1_cs_r;
   assign FLASH2_CS    = f2_cs_r;
   assign FLASH2_WE    = f2_we_r;
   assign FLASH2_ERASE = f2_erase_r;
   assign FAST_CS      = fast_cs_r;
   assign ROM_OFS      = rom_ofs_r;
   assign FLASH_OFS    = flash_ofs_r;
   assign FAST_ADDR    = fast_addr_r;
   assign MEM_WE       = we_r;
   assign ACC_DONE     = done_r;
   assign CPU_WAIT     = wait_r;
   assign BOOT_REGION  = boot_rgn_r;
   assign ROM_MODE     = rom_mode_r;
   assign BLK2_AT_ZERO = blk2_r;
   assign JUMP_REQ     = jump_r;
   assign JUMP_ADDR    = RESET_VECTOR;
endmodule
`default_nettype wire

/* File: design/remap_pkg.sv */
// Constants shared by the remap decoder, the boot checker and the I/O bus.
// Assumes 32-bit byte addresses from the core and 32-bit flash words.
package remap_pkg;
   // Memory windows
   localparam logic [31:0] ROM_SIZE       = 32'h0000_2000;
   localparam logic [31:0] ROM_ALIAS_TOP  = 32'h0003_ffff;
   localparam logic [31:0] ROM_HI_BASE    = 32'h0004_0000;
   localparam logic [31:0] FLASH_BLK_SIZE = 32'h0000_8000;
   localparam logic [31:0] FLASH_ALT_BASE = 32'h0000_8000;
   localparam logic [31:0] BOOT_RGN_SIZE  = 32'h0000_0800;
   // Fast peripherals: former window and its upward relocation
   localparam logic [31:0] FAST_OLD_BASE  = 32'h0006_0000;
   localparam logic [31:0] FAST_SIZE      = 32'h0001_0000;
   localparam logic [31:0] FAST_RELOC     = 32'h0010_0000;
   // Slow peripherals keep their addresses from here upward
   localparam logic [31:0] SLOW_BASE      = 32'hfff7_f600;
   // Checksum words and the regions they cover
   localparam logic [31:0] CK_BLK1_BOOT   = 32'h0000_07fc;
   localparam logic [31:0] CK_BLK2_BOOT   = 32'h0000_87fc;
   localparam logic [31:0] CK_OVERALL     = 32'h0000_0ffc;
   localparam logic [31:0] BLK1_BASE      = 32'h0000_0000;
   localparam logic [31:0] BLK2_BASE      = 32'h0000_8000;
   localparam logic [31:0] WORD_STEP      = 32'h0000_0004;
   // Branch opcode test on the first word of a block
   localparam logic [31:0] BRANCH_MASK    = 32'h0e00_0000;
   localparam logic [31:0] BRANCH_VAL     = 32'h0a00_0000;
   // Management bus execute codes
   localparam logic [7:0]  CMD_EXEC_BLK1  = 8'hf0;
   localparam logic [7:0]  CMD_EXEC_BLK2  = 8'hf7;
   // Vector the core jumps through after the swap
   localparam logic [31:0] RESET_VECTOR   = 32'h0000_0000;
   // Field widths of the memory-side offsets
   localparam int          ROM_OFS_W      = 13;
   localparam int          FLASH_OFS_W    = 15;
endpackage

/* File: design/slow_io_bus.sv */
// Half-rate I/O bus for the slow peripherals.
// Assumes requests arrive as one-cycle pulses on the processor clock.
`timescale 1ns/1ps
`default_nettype none
module slow_io_bus (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        req,
   input  wire logic        we,
   input  wire logic [31:0] addr,
   output logic             io_clk,
   output logic             io_stb,
   output logic             io_we,
   output logic [31:0]      io_addr,
   output logic             busy
);
   import remap_pkg::*;

   logic        div_r;
   logic        pend_r;
   logic        stb_r;
   logic        we_r;
   logic [31:0] addr_r;
   logic        launch;

   // Launch only on the low phase so the strobe spans the high half of one io cycle
   assign launch = pend_r && !div_r && !stb_r;

   // Divide by two; the bus runs at half the core rate
   always_ff @(posedge clk) begin
      if (rst) begin
         div_r <= 1'b0;
      end else begin
         div_r <= !div_r;
      end
   end

   // Hold the request until the io phase lines up
   always_ff @(posedge clk) begin
      if (rst) begin
         pend_r <= 1'b0;
         we_r   <= 1'b0;
         addr_r <= 32'h0000_0000;
      end else if (req) begin
         pend_r <= 1'b1;
         we_r   <= we;
         addr_r <= addr;                          // address unchanged
      end else if (launch) begin
         pend_r <= 1'b0;
      end
   end

   // Strobe stands for one core cycle, half an io clock period
   always_ff @(posedge clk) begin
      if (rst) begin
         stb_r <= 1'b0;
      end else if (launch) begin
         stb_r <= 1'b1;
      end else if (div_r) begin
         stb_r <= 1'b0;
      end
   end

   assign io_clk  = div_r;
   assign io_stb  = stb_r;
   assign io_we   = we_r;
   assign io_addr = addr_r;
   assign busy    = pend_r || stb_r;
endmodule
`default_nettype wire

/* File: test/flash_word_model.sv */
// Flash read port model answering the boot checker after LAT cycles.
// Assumes one read outstanding; data is scrambled outside valid cycles.
`timescale 1ns/1ps
`default_nettype none
module flash_word_model #(
   parameter int LAT = 2
) (
   input  wire logic        clk,
   input  wire logic        rd_req,
   input  wire logic [31:0] rd_addr,
   output logic [31:0]      data,
   output logic             dvalid
);
   logic [31:0] addr_r;
   int          cnt_r = 0;
   initial data = 32'h5a5a_a5a5;
   // Block one has a branch and a matching checksum; block two is erased
   function automatic logic [31:0] word(input logic [31:0] a);
      if (a == 32'h0 || a == 32'h7fc) return 32'h0a00_0000;
      if (a == 32'hffc) return 32'h1400_0000;
      return (a >= 32'h8000) ? 32'hffff_ffff : 32'h0;
   endfunction
   // Inverting idle data keeps a stale word from passing as an answer
   always @(posedge clk) begin
      dvalid <= 1'h0;
      data <= ~data;
      if (rd_req) begin
         addr_r <= rd_addr;
         cnt_r <= LAT;
      end else if (cnt_r == 1) begin
         dvalid <= 1'h1;
         data <= word(addr_r);
         cnt_r <= 0;
      end else if (cnt_r > 1) begin
         cnt_r <= cnt_r - 1;
      end
   end
endmodule
`default_nettype wire

/* File: test/memory_remap_test.sv */
// Self-checking bench for the remap decoder with a flash word model.
// Assumes remap_pkg, the design, checker and model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module memory_remap_test;
   import remap_pkg::*;
   logic SYS_CLK = 1'h0, RST = 1'h1, CPU_REQ = 1'h0, CPU_WE = 1'h0;
   logic [31:0] CPU_ADDR = 32'h0;
   logic FLASH1_BUSY = 1'h0, FLASH2_BUSY = 1'h0, F2_WR_EN = 1'h0;
   logic F2_LOCK = 1'h0, F2_ERASE_REQ = 1'h0, BOOT_SPLIT = 1'h0;
   logic BOOT_START = 1'h0, MGMT_CMD_VALID = 1'h0;
   logic [7:0] MGMT_CMD = 8'h0;
   wire logic [31:0] BOOT_DATA;
   wire logic BOOT_DVALID;
   logic ROM_CS, FLASH1_CS, FLASH2_CS, FLASH2_WE, FLASH2_ERASE, FAST_CS;
   logic [ROM_OFS_W-1:0] ROM_OFS;
   logic [FLASH_OFS_W-1:0] FLASH_OFS;
   logic [31:0] FAST_ADDR, IO_ADDR, BOOT_RD_ADDR, JUMP_ADDR;
   logic MEM_WE, ACC_DONE, CPU_WAIT, BOOT_REGION, IO_CLK, IO_STB, IO_WE;
   logic BOOT_RD_REQ, BOOT_DONE, ROM_MODE, BLK2_AT_ZERO, JUMP_REQ;
   int miscompares = 0, n_checks = 0;
   always #25 SYS_CLK = ~SYS_CLK;
   memory_remap DUT (.*);
   flash_word_model #(.LAT(2)) u_flash (.clk(SYS_CLK), .rd_req(BOOT_RD_REQ),
      .rd_addr(BOOT_RD_ADDR), .data(BOOT_DATA), .dvalid(BOOT_DVALID));
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Inputs move 2 ns after the edge so no sampling race is possible
   task automatic tick;
      @(posedge SYS_CLK);
      #2;
   endtask
   // One access; the answer cycle is current when this returns
   task automatic acc(input logic [31:0] a, input logic w);
      tick;
      CPU_ADDR = a;
      CPU_WE = w;
      CPU_REQ = 1'h1;
      tick;
      CPU_REQ = 1'h0;
   endtask
   task automatic wait_for(ref logic s, input string what);
      int i;
      for (i = 0; i < 9000 && s !== 1'h1; i++) tick;
      chk(what, 32'h1, {31'h0, s});
   endtask
   task automatic mgmt(input logic [7:0] c);
      tick;
      MGMT_CMD = c;
      MGMT_CMD_VALID = 1'h1;
      tick;
      MGMT_CMD_VALID = 1'h0;
      wait_for(JUMP_REQ, "jump");
   endtask
   task automatic t_rom_and_periph;
      acc(32'h0003_fffc, 1'h0);
      chk("rom ofs", 32'h1ffc, {19'h0, ROM_OFS});
      acc(32'h4, 1'h1);
      chk("rom wr cs", 32'h0, {31'h0, ROM_CS});
      acc(32'h0016_0010, 1'h0);
      chk("fast addr", 32'h10, FAST_ADDR);
      acc(32'h0020_0000, 1'h1);
      chk("unmapped", 32'h1, {31'h0, ACC_DONE &
         ~(ROM_CS | FLASH1_CS | FLASH2_CS | FAST_CS)});
      acc(SLOW_BASE, 1'h1);
      wait_for(IO_STB, "io strobe");
      chk("io addr", SLOW_BASE, IO_ADDR);
      chk("io we", 32'h1, {31'h0, IO_WE});
   endtask
   task automatic t_boot;
      tick;
      BOOT_START = 1'h1;
      tick;
      BOOT_START = 1'h0;
      wait_for(BOOT_DONE, "boot done");
      wait_for(JUMP_REQ, "boot jump");
      chk("mode", 32'h0, {31'h0, ROM_MODE | BLK2_AT_ZERO});
      chk("jump vec", RESET_VECTOR, JUMP_ADDR);
      BOOT_SPLIT = 1'h1;
      acc(32'h10, 1'h0);
      chk("blk1 at 0", 32'h1, {31'h0, FLASH1_CS});
      chk("boot rgn", 32'h1, {31'h0, BOOT_REGION});
      chk("flash ofs", 32'h10, {17'h0, FLASH_OFS});
   endtask
   task automatic t_swap;
      mgmt(CMD_EXEC_BLK2);
      chk("blk2 zero", 32'h1, {31'h0, BLK2_AT_ZERO});
      FLASH1_BUSY = 1'h1;
      acc(32'h10, 1'h0);
      chk("blk2 fetch", 32'h1, {31'h0, FLASH2_CS & ~CPU_WAIT});
      acc(32'h8010, 1'h0);
      chk("blk1 stall", 32'h1, {31'h0, CPU_WAIT & ~FLASH1_CS});
      FLASH1_BUSY = 1'h0;
      F2_WR_EN = 1'h1;
      F2_LOCK = 1'h1;
      acc(32'h20, 1'h1);
      chk("locked we", 32'h1, {31'h0, FLASH2_CS & ~FLASH2_WE});
      F2_LOCK = 1'h0;
      acc(32'h20, 1'h1);
      chk("blk2 we", 32'h1, {31'h0, FLASH2_WE});
      acc(32'h8010, 1'h0);
      chk("blk1 alt", 32'h1, {31'h0, FLASH1_CS});
      F2_LOCK = 1'h1;
      F2_ERASE_REQ = 1'h1;
      tick;
      chk("locked erase", 32'h0, {31'h0, FLASH2_ERASE});
      F2_LOCK = 1'h0;
      tick;
      chk("blk2 erase", 32'h1, {31'h0, FLASH2_ERASE});
      F2_ERASE_REQ = 1'h0;
      mgmt(CMD_EXEC_BLK1);
      chk("blk1 back", 32'h0, {31'h0, BLK2_AT_ZERO});
   endtask
   // Main sequence, ending with a second reset in mid-run
   initial begin
      repeat (4) @(posedge SYS_CLK);
      #2;
      RST = 1'h0;
      chk("reset mode", 32'h1, {31'h0, ROM_MODE});
      t_rom_and_periph();
      t_boot();
      t_swap();
      RST = 1'h1;
      repeat (4) tick;
      RST = 1'h0;
      chk("rereset", 32'h1, {31'h0, ROM_MODE & ~BLK2_AT_ZERO});
      repeat (2) tick;
      print_verdict();
   end
   // Watchdog well beyond the boot scan length
   initial begin
      #2_000_000;
      miscompares++;
      print_verdict();
   end
endmodule
bind memory_remap remap_props u_props (.*);
`default_nettype wire

/* File: test/remap_props.sv */
// Checker for the remap decoder; sees only the top module's ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module remap_props (
   input wire logic                         SYS_CLK,
   input wire logic                         RST,
   input wire logic                         CPU_REQ,
   input wire logic                         CPU_WE,
   input wire logic [31:0]                  CPU_ADDR,
   input wire logic                         FLASH2_BUSY,
   input wire logic                         F2_WR_EN,
   input wire logic                         F2_LOCK,
   input wire logic                         ROM_CS,
   input wire logic                         FLASH1_CS,
   input wire logic                         FLASH2_CS,
   input wire logic                         FLASH2_WE,
   input wire logic                         FAST_CS,
   input wire logic [remap_pkg::ROM_OFS_W-1:0] ROM_OFS,
   input wire logic [31:0]                  FAST_ADDR,
   input wire logic                         ACC_DONE,
   input wire logic                         IO_CLK,
   input wire logic                         ROM_MODE,
   input wire logic                         BLK2_AT_ZERO,
   input wire logic                         JUMP_REQ
);
   import remap_pkg::*;
   // Relocated fast window; unsigned subtraction doubles as range test
   localparam logic [31:0] FAST_NEW = FAST_OLD_BASE + FAST_RELOC;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   reset_rom_a: assert property ($past(RST) |-> ROM_MODE && !BLK2_AT_ZERO)
      else $error("mode after reset is not ROM with block one at zero");
   rom_alias_a: assert property (CPU_REQ && !CPU_WE && ROM_MODE &&
      CPU_ADDR <= ROM_ALIAS_TOP |=> ROM_CS && ROM_OFS == $past(CPU_ADDR[12:0]))
      else $error("ROM alias read not selected at the wrapped offset");
   fast_reloc_a: assert property (CPU_REQ && CPU_ADDR - FAST_NEW < FAST_SIZE
      |=> FAST_CS && FAST_ADDR == $past(CPU_ADDR) - FAST_NEW)
      else $error("fast peripheral access not decoded at the relocated base");
   unmapped_a: assert property (CPU_REQ && CPU_ADDR >= FAST_NEW + FAST_SIZE
      && CPU_ADDR < SLOW_BASE |=> ACC_DONE && !(ROM_CS || FLASH1_CS || FLASH2_CS || FAST_CS))
      else $error("unmapped access touched a resource or did not complete");
   io_half_a: assert property (!$past(RST) |-> IO_CLK != $past(IO_CLK))
      else $error("slow bus clock is not half the core clock");
   flash_order_a: assert property ($fell(ROM_MODE) |-> !JUMP_REQ
      ##[1:8] JUMP_REQ) else $error("flash entry jump out of order or missing");
   blk_swap_a: assert property (CPU_REQ && BLK2_AT_ZERO && !FLASH2_BUSY &&
      CPU_ADDR < FLASH_BLK_SIZE |=> FLASH2_CS && !FLASH1_CS)
      else $error("block two not decoded at zero after the swap");
   f2_guard_a: assert property (FLASH2_WE |-> $past(F2_WR_EN && !F2_LOCK && CPU_WE))
      else $error("block two write passed without enable or under lock");
endmodule
`default_nettype wire
